// *** src/asl_map.vh ***
`ifndef ASL_MAP_VH
`define ASL_MAP_VH

// Register byte offsets.
`define ASL_CTRL      8'h00
`define ASL_STATUS    8'h04
`define ASL_PLLCFG    8'h08
`define ASL_VCOTRIM   8'h0C
`define ASL_LINKCFG   8'h10
`define ASL_CALCFG    8'h14
`define ASL_TRIGGER_CLOCK_OUTPUT   8'h18
`define ASL_LINKINFO  8'h1C

// Control register bit positions.
`define ASL_C_SOFTRST  0
`define ASL_C_PLLRST   1
`define ASL_C_VCOCALEN 2
`define ASL_C_LINKEN   3
`define ASL_C_CALEN    4
`define ASL_C_SWTRIG   5
`define ASL_C_PINTRIG  6
`define ASL_C_OVREN    7
`define ASL_C_TRIGOEN  8
`define ASL_CTRL_W     9

// Reset values.
`define ASL_CTRL_RST   9'h03A
`define ASL_PLLCFG_RST 24'h000000
`define ASL_LINK_RST   17'h00000
`define ASL_CAL_RST    17'h00000
`define ASL_VCOBIAS    8'h4A

// Link modes from this value upward use 64B/66B coding.
`define ASL_MODE_66B_MIN 5'h08
`define ASL_MODE8        5'h08
`define ASL_M8_LANES     4'h4
`define ASL_M8_RATEX1000 17'h0_3057

// Timing, in ns, and cycle counts at the clock period.
`define ASL_CLK_NS    40
`define ASL_INIT_NS   2000
`define ASL_VCOCAL_NS 20000
`define ASL_LOCK_NS   10000
`define ASL_CAL_NS    40000
`define ASL_CYC(t) (((t) + `ASL_CLK_NS - 1) / `ASL_CLK_NS)
`define ASL_INIT_CYC   `ASL_CYC(`ASL_INIT_NS)
`define ASL_VCOCAL_CYC `ASL_CYC(`ASL_VCOCAL_NS)
`define ASL_LOCK_CYC   `ASL_CYC(`ASL_LOCK_NS)
`define ASL_CAL_CYC    `ASL_CYC(`ASL_CAL_NS)

`endif

// *** src/asl_timer.v ***
`timescale 1ns/100ps
`default_nettype none

module asl_timer #(
  parameter CYC = 16
) (
  input  wire ref_clk,
  input  wire sys_rst,
  input  wire start,
  input  wire halt,
  output wire busy,
  output reg  doneP
);
  reg [12:0] cnt_r;

  // Counts down from CYC after a start; halt aborts without a done pulse.
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_r <= 13'h0000;
      doneP <= 1'b0;
    end else begin
      doneP <= 1'b0;
      if (halt) begin
        cnt_r <= 13'h0000;
      end else if (start) begin
        cnt_r <= CYC[12:0];
      end else if (cnt_r != 13'h0000) begin
        cnt_r <= cnt_r - 13'h0001;
        doneP <= (cnt_r == 13'h0001);
      end
    end
  end

  assign busy = (cnt_r != 13'h0000);
endmodule // asl_timer

`default_nettype wire

// *** src/asl_startup.v ***
// Function
// - Init-done flag set; host polls it.
// - PLL reset release starts calibration, lock.
// - Link enable low halts link machine.
// - Calibration enable low halts calibration.
// - Report VCO calibration done and lock.
// - Foreground calibration on bit or pin rise.
// - Status pin and done bit after calibration.
// - 8B/10B waits for sync; 64B/66B ignores.
// - Data valid needs link up and calibration.
// - Mode 8: four lanes, rate 12.375x.
//
// Register access over APB and the register offsets were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "asl_map.vh"

module asl_startup #(
  parameter INIT_CYC   = `ASL_INIT_CYC,
  parameter VCOCAL_CYC = `ASL_VCOCAL_CYC,
  parameter LOCK_CYC   = `ASL_LOCK_CYC,
  parameter CAL_CYC    = `ASL_CAL_CYC
) (
  input  wire        ref_clk,
  input  wire        sys_rst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        pllEnableStrap,
  input  wire        refInputSelectStrap,
  input  wire        auxClockCfgStrap0,
  input  wire        auxClockCfgStrap1,
  input  wire        powerDownPin,
  input  wire        singleEndedSyncPin,
  input  wire        timestampDiffPins,
  input  wire        calibrationTriggerPin,
  input  wire        overRangeIn,
  output reg         calibrationStatusPin,
  output reg         repeatedRefOutEn,
  output reg         trigClockOutEn,
  output reg  [7:0]  trigOutMode,
  output reg  [23:0] pllDivCfg,
  output reg  [7:0]  vcoTrimValue,
  output reg         linkSendCodeGroups,
  output reg         linkSendData,
  output reg  [4:0]  linkMultiframeLen,
  output reg         dataValid
);
  localparam [2:0] L_HALT = 3'b001;
  localparam [2:0] L_SYNC = 3'b010;
  localparam [2:0] L_DATA = 3'b100;

  reg [`ASL_CTRL_W-1:0] ctrl_r;
  reg [16:0] linkCfg_r;
  reg [16:0] calCfg_r;
  reg        strapDone_r;
  reg        pllUsed_r;
  reg        refSel_r;
  reg [1:0]  auxCfg_r;
  reg        initDone_r;
  reg        vcoDone_r;
  reg        locked_r;
  reg        calDone_r;
  reg        calPin_r;
  reg        pllRstOld_r;
  reg        calEnOld_r;
  reg [2:0]  linkSt_r;
  reg [2:0]  linkSt_nxt;
  reg [31:0] rd;
  reg        mapped;

  wire wrEn    = psel & penable & pwrite;
  wire setup   = psel & ~penable;
  wire softRst = wrEn && paddr == `ASL_CTRL && pwdata[`ASL_C_SOFTRST];
  wire pllRst  = ctrl_r[`ASL_C_PLLRST];
  wire calEn   = ctrl_r[`ASL_C_CALEN];
  wire linkEn  = ctrl_r[`ASL_C_LINKEN];
  wire [4:0] mode = linkCfg_r[4:0];
  wire is66    = (mode >= `ASL_MODE_66B_MIN);
  wire bgMode  = calCfg_r[0];
  wire clkOk   = pllUsed_r ? locked_r : 1'b1;

  // Registers answer in the access cycle with no wait states.
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // Straps are caught on the first edge after reset is released.
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      strapDone_r <= 1'b0;
      pllUsed_r   <= 1'b0;
      refSel_r    <= 1'b0;
      auxCfg_r    <= 2'h0;
    end else if (!strapDone_r) begin
      strapDone_r <= 1'b1;
      pllUsed_r   <= pllEnableStrap;
      refSel_r    <= refInputSelectStrap;
      auxCfg_r    <= {auxClockCfgStrap1, auxClockCfgStrap0};
    end
  end

  // Writable configuration; a soft reset restores the defaults.
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_r       <= `ASL_CTRL_RST;
      pllDivCfg    <= `ASL_PLLCFG_RST;
      vcoTrimValue <= 8'h00;
      linkCfg_r    <= `ASL_LINK_RST;
      calCfg_r     <= `ASL_CAL_RST;
      trigOutMode  <= 8'h00;
    end else if (softRst) begin
      ctrl_r       <= `ASL_CTRL_RST;
      pllDivCfg    <= `ASL_PLLCFG_RST;
      vcoTrimValue <= 8'h00;
      linkCfg_r    <= `ASL_LINK_RST;
      calCfg_r     <= `ASL_CAL_RST;
      trigOutMode  <= 8'h00;
    end else if (wrEn) begin
      case (paddr)
        `ASL_CTRL:    ctrl_r <= {pwdata[`ASL_CTRL_W-1:1], 1'b0};
        `ASL_PLLCFG:  pllDivCfg <= pwdata[23:0];
        `ASL_VCOTRIM: vcoTrimValue <= pwdata[7:0];
        `ASL_LINKCFG: linkCfg_r <= pwdata[16:0];
        `ASL_CALCFG:  calCfg_r <= pwdata[16:0];
        `ASL_TRIGGER_CLOCK_OUTPUT: trigOutMode <= pwdata[7:0];
        default:      ctrl_r <= ctrl_r;
      endcase
    end
  end

  wire initBusy;
  wire initDoneP;
  wire vcoBusy;
  wire vcoDoneP;
  wire lockBusy;
  wire lockDoneP;
  wire calBusy;
  wire calDoneP;

  // Edge history for the PLL reset release and calibration enable.
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pllRstOld_r <= 1'b1;
      calEnOld_r  <= 1'b1;  // Matches the enabled reset state, no false edge.
    end else begin
      pllRstOld_r <= pllRst;
      calEnOld_r  <= calEn;
    end
  end

  wire pllRelease = pllRstOld_r & ~pllRst & pllUsed_r & initDone_r;
  wire vcoStart   = pllRelease & ctrl_r[`ASL_C_VCOCALEN];
  wire lockStart  = vcoDoneP | (pllRelease & ~ctrl_r[`ASL_C_VCOCALEN]);
  wire swTrig = wrEn && paddr == `ASL_CTRL &&
                pwdata[`ASL_C_SWTRIG] && !ctrl_r[`ASL_C_SWTRIG];
  wire pinTrig = ctrl_r[`ASL_C_PINTRIG] & calibrationTriggerPin & ~calPin_r;
  wire calReady = calEn & initDone_r & clkOk & ~calBusy;
  wire calStart = calReady & ((~bgMode & (swTrig | pinTrig)) |
                              (bgMode & calEn & ~calEnOld_r));

  // Internal initialization after reset or soft reset.
  asl_timer #(.CYC(INIT_CYC)) u_init (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .start   (softRst | (strapDone_r & ~initDone_r & ~initBusy)),
    .halt    (1'b0),
    .busy    (initBusy),
    .doneP   (initDoneP)
  );

  // VCO trim calibration, halted while the PLL is held in reset.
  asl_timer #(.CYC(VCOCAL_CYC)) u_vco (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .start   (vcoStart),
    .halt    (pllRst | softRst),
    .busy    (vcoBusy),
    .doneP   (vcoDoneP)
  );

  // Lock acquisition after calibration or a manual trim.
  asl_timer #(.CYC(LOCK_CYC)) u_lock (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .start   (lockStart),
    .halt    (pllRst | softRst),
    .busy    (lockBusy),
    .doneP   (lockDoneP)
  );

  // Calibration run, stopped whenever calibration is disabled.
  asl_timer #(.CYC(CAL_CYC)) u_cal (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .start   (calStart),
    .halt    (~calEn | softRst),
    .busy    (calBusy),
    .doneP   (calDoneP)
  );

  // Status flags; each done event wins over a clear in the same cycle.
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      initDone_r <= 1'b0;
      vcoDone_r  <= 1'b0;
      locked_r   <= 1'b0;
      calDone_r  <= 1'b0;
      calPin_r   <= 1'b0;
    end else begin
      calPin_r <= calibrationTriggerPin;
      if (initDoneP)
        initDone_r <= 1'b1;
      else if (softRst)
        initDone_r <= 1'b0;
      if (vcoDoneP | (pllRelease & ~ctrl_r[`ASL_C_VCOCALEN]))
        vcoDone_r <= 1'b1;
      else if (pllRst | softRst)
        vcoDone_r <= 1'b0;
      if (lockDoneP)
        locked_r <= 1'b1;
      else if (pllRst | softRst)
        locked_r <= 1'b0;
      if (calDoneP)
        calDone_r <= 1'b1;
      else if (calStart | softRst)
        calDone_r <= 1'b0;
    end
  end

  wire syncIn = linkCfg_r[16] ? timestampDiffPins : singleEndedSyncPin;

  // Link state: halted, code-group sync, or sending data.
  always @* begin
    linkSt_nxt = linkSt_r;
    if (!linkEn || !initDone_r) begin
      linkSt_nxt = L_HALT;
    end else begin
      case (linkSt_r)
        L_HALT: linkSt_nxt = is66 ? L_DATA : L_SYNC;
        L_SYNC: linkSt_nxt = (is66 | syncIn) ? L_DATA : L_SYNC;
        L_DATA: linkSt_nxt = (!is66 && !syncIn) ? L_SYNC : L_DATA;
        default: linkSt_nxt = L_HALT;
      endcase
    end
  end

  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst)
      linkSt_r <= L_HALT;
    else
      linkSt_r <= linkSt_nxt;
  end

  // Registered pin and link outputs.
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      calibrationStatusPin <= 1'b0;
      repeatedRefOutEn     <= 1'b0;
      trigClockOutEn       <= 1'b0;
      linkSendCodeGroups   <= 1'b0;
      linkSendData         <= 1'b0;
      linkMultiframeLen    <= 5'h00;
      dataValid            <= 1'b0;
    end else begin
      calibrationStatusPin <= calCfg_r[16] ?
        (overRangeIn & ctrl_r[`ASL_C_OVREN]) : calDone_r;
      repeatedRefOutEn   <= ~powerDownPin;
      trigClockOutEn     <= ctrl_r[`ASL_C_TRIGOEN] & ~powerDownPin;
      linkSendCodeGroups <= (linkSt_nxt == L_SYNC);
      linkSendData       <= (linkSt_nxt == L_DATA);
      linkMultiframeLen  <= is66 ? 5'h00 : linkCfg_r[12:8];
      dataValid <= (linkSt_nxt == L_DATA) & calDone_r;
    end
  end

  // Read decode.
  always @* begin
    rd = 32'h0000_0000;
    mapped = 1'b1;
    case (paddr)
      `ASL_CTRL:     rd[`ASL_CTRL_W-1:0] = ctrl_r;
      `ASL_STATUS:   rd[11:0] = {auxCfg_r, refSel_r & ~pllUsed_r, refSel_r,
                                 pllUsed_r, dataValid, linkSendData,
                                 calBusy, calDone_r, locked_r, vcoDone_r,
                                 initDone_r};
      `ASL_PLLCFG:   rd[23:0] = pllDivCfg;
      `ASL_VCOTRIM:  rd[7:0] = vcoTrimValue;
      `ASL_LINKCFG:  rd[16:0] = linkCfg_r;
      `ASL_CALCFG:   rd[16:0] = calCfg_r;
      `ASL_TRIGGER_CLOCK_OUTPUT:  rd[7:0] = trigOutMode;
      `ASL_LINKINFO: rd = (mode == `ASL_MODE8) ?
                          {11'h000, `ASL_M8_RATEX1000, `ASL_M8_LANES} :
                          32'h0000_0000;
      default:       mapped = 1'b0;
    endcase
  end

  // Read data is captured in the setup cycle for the access cycle.
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst)
      prdata <= 32'h0000_0000;
    else if (setup && !pwrite)
      prdata <= rd;
  end
endmodule // asl_startup

`default_nettype wire

// *** verif/asl_rx_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// Link receiver stand-in: asks for data once code groups have run a while.
module asl_rx_model #(
  parameter int DLY = 4
) (
  input  wire logic ref_clk,
  input  wire logic sys_rst,
  input  wire logic linkSendCodeGroups,
  input  wire logic linkSendData,
  output var  logic syncReq
);
  logic [3:0] cnt_r;
  // Request drops whenever the link goes quiet, so a halt restarts it.
  // The receiver core runs on the reference clock itself.
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_r <= 4'h0;
      syncReq <= 1'b0;
    end else if (!linkSendCodeGroups && !linkSendData) begin
      cnt_r <= 4'h0;
      syncReq <= 1'b0;
    end else if (cnt_r != DLY[3:0]) begin
      cnt_r <= cnt_r + 4'h1;
    end else begin
      syncReq <= 1'b1;
    end
  end
endmodule // asl_rx_model
`default_nettype wire

// *** verif/asl_startup_checker.sv ***
`timescale 1ns/100ps
`default_nettype none
// Watches bus answers, pin gating and link sequencing at the ports.
module asl_startup_checker (
  input wire logic        ref_clk,
  input wire logic        sys_rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        powerDownPin,
  input wire logic        singleEndedSyncPin,
  input wire logic        timestampDiffPins,
  input wire logic        calibrationStatusPin,
  input wire logic        repeatedRefOutEn,
  input wire logic        trigClockOutEn,
  input wire logic        linkSendCodeGroups,
  input wire logic        linkSendData,
  input wire logic        dataValid
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // Bus answers at once and, at word-aligned places, refuses only those past the map.
  a_bus_ready: assert property (psel && penable |-> pready)
    else $error("no ready");
  a_unmapped_err: assert property (psel && penable
    && paddr[1:0] == 2'h0 |-> pslverr == (paddr > 8'h1C))
    else $error("bad slverr");
  // Clock outputs follow the power-down pin one edge later.
  a_refout_pd: assert property (!$past(sys_rst)
    |-> repeatedRefOutEn == !$past(powerDownPin)) else $error("refout");
  a_trig_pd: assert property (trigClockOutEn
    |-> !$past(powerDownPin)) else $error("trig out");
  // Clearing link enable empties the link outputs two edges on.
  a_link_halt: assert property (psel && penable && pwrite
    && paddr == 8'h00 && !pwdata[3] && !pwdata[0]
    |-> ##2 !linkSendData && !linkSendCodeGroups) else $error("no halt");
  a_valid_link: assert property (dataValid
    |-> linkSendData || $past(linkSendData)) else $error("valid early");
  a_sync_gate: assert property ($past(linkSendCodeGroups)
    && linkSendData |-> $past(singleEndedSyncPin || timestampDiffPins))
    else $error("sync");
  a_cal_span: assert property ($fell(calibrationStatusPin)
    |-> !calibrationStatusPin [*4]) else $error("cal short");
endmodule // asl_startup_checker
bind asl_startup asl_startup_checker i_chk (.ref_clk(ref_clk),
  .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .powerDownPin(powerDownPin), .singleEndedSyncPin(singleEndedSyncPin),
  .timestampDiffPins(timestampDiffPins),
  .calibrationStatusPin(calibrationStatusPin),
  .repeatedRefOutEn(repeatedRefOutEn), .trigClockOutEn(trigClockOutEn),
  .linkSendCodeGroups(linkSendCodeGroups), .linkSendData(linkSendData),
  .dataValid(dataValid));
`default_nettype wire

// *** verif/adc_startup_link_bringup_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module adc_startup_link_bringup_tb;
  logic ref_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, er;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, rd, prdata;
  logic pllEnableStrap = 1, refInputSelectStrap = 0, auxClockCfgStrap0 = 1;
  logic auxClockCfgStrap1 = 0, powerDownPin = 0, singleEndedSyncPin;
  logic timestampDiffPins = 0, calibrationTriggerPin = 0, overRangeIn = 0;
  logic pready, pslverr, calibrationStatusPin, repeatedRefOutEn;
  logic trigClockOutEn, linkSendCodeGroups, linkSendData, dataValid;
  logic [7:0]  trigOutMode, vcoTrimValue;
  logic [23:0] pllDivCfg;
  logic [4:0]  linkMultiframeLen;
  int err_count = 0, n_checks = 0, cyc = 0, i;
  asl_startup #(.INIT_CYC(6), .VCOCAL_CYC(8), .LOCK_CYC(5), .CAL_CYC(8))
    i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .pllEnableStrap(pllEnableStrap),
      .refInputSelectStrap(refInputSelectStrap),
      .auxClockCfgStrap0(auxClockCfgStrap0),
      .auxClockCfgStrap1(auxClockCfgStrap1), .powerDownPin(powerDownPin),
      .singleEndedSyncPin(singleEndedSyncPin),
      .timestampDiffPins(timestampDiffPins),
      .calibrationTriggerPin(calibrationTriggerPin),
      .overRangeIn(overRangeIn),
      .calibrationStatusPin(calibrationStatusPin),
      .repeatedRefOutEn(repeatedRefOutEn), .trigClockOutEn(trigClockOutEn),
      .trigOutMode(trigOutMode), .pllDivCfg(pllDivCfg),
      .vcoTrimValue(vcoTrimValue), .linkSendCodeGroups(linkSendCodeGroups),
      .linkSendData(linkSendData), .linkMultiframeLen(linkMultiframeLen),
      .dataValid(dataValid));
  asl_rx_model i_rx (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .linkSendCodeGroups(linkSendCodeGroups), .linkSendData(linkSendData),
    .syncReq(singleEndedSyncPin));
  // Free-running 25 MHz clock.
  initial begin
    forever #20 ref_clk = ~ref_clk;
  end
  // One APB transfer; read data and error taken at the ready edge.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Read status until the given bit is set, within a bounded count.
  task automatic poll(input int b);
    for (i = 0; i < 200; i++) begin
      bus(0, 8'h04, 0);
      if (rd[b] === 1'b1) break;
    end
    chk(rd[b], 1);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Cuts a hang short.
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      conclude;
    end
  end
  // Bring-up sequence, then mode, trigger and gating checks.
  initial begin
    repeat (16) @(posedge ref_clk);
    sys_rst <= 1'b0;
    bus(0, 8'h00, 0);
    chk(rd, 32'h3A);
    poll(0);
    chk(rd[9:7], 3'h1);
    bus(1, 8'h00, 32'h26);
    bus(1, 8'h08, 32'h4A2104);
    @(negedge ref_clk);
    chk(pllDivCfg, 24'h4A2104);
    bus(1, 8'h00, 32'h24);
    bus(0, 8'h04, 0);
    chk(rd[2:1], 2'h0);
    poll(2);
    chk(rd[1], 1);
    $display("pll test done");
    bus(1, 8'h10, 32'h0F02);
    bus(1, 8'h14, 32'h0);
    bus(1, 8'h18, 32'h81);
    bus(1, 8'h00, 32'h1BC);
    for (i = 0; i < 50 && linkSendData !== 1'b1; i++) @(posedge ref_clk);
    chk(linkSendData, 1);
    chk(linkMultiframeLen, 5'h0F);
    chk({trigClockOutEn, trigOutMode}, 9'h181);
    bus(1, 8'h00, 32'h19C);
    bus(1, 8'h00, 32'h1BC);
    bus(0, 8'h04, 0);
    chk(rd[4:3], 2'h2);
    poll(3);
    repeat (2) @(posedge ref_clk);
    chk({calibrationStatusPin, dataValid}, 2'h3);
    bus(1, 8'h00, 32'h1FC);
    calibrationTriggerPin <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk(calibrationStatusPin, 0);
    poll(3);
    calibrationTriggerPin <= 1'b0;
    $display("cal test done");
    bus(1, 8'h00, 32'h1F4);
    repeat (3) @(posedge ref_clk);
    chk(linkSendData, 0);
    bus(1, 8'h10, 32'h08);
    bus(1, 8'h00, 32'h1FC);
    repeat (3) @(posedge ref_clk);
    chk({linkSendData, singleEndedSyncPin}, 2'h2);
    chk(linkMultiframeLen, 0);
    bus(0, 8'h1C, 0);
    chk(rd, {11'h000, 17'h03057, 4'h4});
    bus(1, 8'h14, 32'h10000);
    repeat (5) @(posedge ref_clk);
    chk(calibrationStatusPin, 0);
    overRangeIn <= 1'b1;
    repeat (2) @(posedge ref_clk);
    chk(calibrationStatusPin, 1);
    bus(0, 8'h20, 0);
    chk({er, rd[30:0]}, 32'h80000000);
    bus(1, 8'h00, 32'h1);
    bus(0, 8'h04, 0);
    chk(rd[0], 0);
    poll(0);
    bus(1, 8'h0C, 32'h5A);
    bus(1, 8'h00, 32'h138);
    poll(2);
    chk(rd[1], 1);
    chk({trigClockOutEn, vcoTrimValue}, 9'h15A);
    powerDownPin <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk({repeatedRefOutEn, trigClockOutEn}, 0);
    $display("link test done");
    conclude;
  end
endmodule // adc_startup_link_bringup_tb
`default_nettype wire
